/* design/seeac_params.svh */
`ifndef SEEAC_PARAMS_SVH
`define SEEAC_PARAMS_SVH
// Function
// R1 - Start bit launches one EEPROM cycle
// R2 - Command bit: zero reads, one writes
// R3 - Error bit 2 flags missing acknowledge
// R4 - Bit 3 shows autoload success, read clears
// R5 - Bit 4 shows configuration loaded from EEPROM
// R6 - Bit 5 disables autoload, resets to one
// R7 - Rate field: 01b divides by 1024, 11b test
// R8 - Serial clock derived from core clock
// R9 - Bits 15:9 hold EEPROM word address
// R10 - Bits 31:16 write data, read result
// R11 - All fields share one register at BCh
// R12 - Software sets fields, waits for completion
// R13 - Start bit clears when cycle finishes

// Register map, byte addresses
`define SEEAC_CTRL_OFS 8'hBC
`define SEEAC_STAT_OFS 8'hF0
`define SEEAC_MASK_OFS 8'hF4

// Control register fields
`define SEEAC_START_BIT 0
`define SEEAC_CMD_BIT 1
`define SEEAC_ERR_BIT 2
`define SEEAC_ALOK_BIT 3
`define SEEAC_ALST_BIT 4
`define SEEAC_ALDIS_BIT 5
`define SEEAC_RATE_LSB 6
`define SEEAC_RATE_MSB 7
`define SEEAC_RSVD_BIT 8
`define SEEAC_ADDR_LSB 9
`define SEEAC_ADDR_MSB 15
`define SEEAC_DATA_LSB 16
`define SEEAC_DATA_MSB 31

// Reset values
`define SEEAC_CMD_RST 1'h0
`define SEEAC_ALDIS_RST 1'h1
`define SEEAC_RATE_RST 2'h1
`define SEEAC_ADDR_RST 7'h00
`define SEEAC_DATA_RST 16'h0000

// Clock rates
`define SEEAC_CORE_MHZ 125
`define SEEAC_RATE_NORMAL 2'h1
`define SEEAC_RATE_TEST 2'h3
`define SEEAC_DIV_NORMAL 1024
`define SEEAC_DIV_TEST 4

// Serial frame
`define SEEAC_OP_READ 2'h2
`define SEEAC_OP_WRITE 2'h1
`define SEEAC_RD_BITS 5'h1B
`define SEEAC_WR_BITS 5'h1A
`define SEEAC_DUMMY_POS 16
`define SEEAC_POLL_LIMIT 12'hFFF

// Interrupt status bits
`define SEEAC_IRQ_DONE 0
`define SEEAC_IRQ_ERR 1
`define SEEAC_IRQ_AUTO 2

// Autoload image: signature word, then words 1..count; signature value arbitrary
`define SEEAC_AL_SIG 16'hA5C3
`define SEEAC_AL_WORDS 7'h08
`endif

/* design/seeac_pkg.sv */
package seeac_pkg;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01,
        SER_GAP = 2'b10,
        SER_POLL = 2'b11
    } seeac_ser_state_t;

    typedef enum logic [1:0] {
        AL_ARMED = 2'b00,
        AL_RUN = 2'b01,
        AL_OVER = 2'b10
    } seeac_al_state_t;
endpackage

/* design/seeac_ser_if.sv */
`timescale 1ns/1ns
interface seeac_ser_if;
    logic req;
    logic wr;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic busy;
    logic done;
    logic err;
    logic [15:0] rdata;
    logic run;
    logic rise;
    logic fall;

    modport ctrl (output req, output wr, output addr, output wdata,
                  input busy, input done, input err, input rdata);
    modport eng (input req, input wr, input addr, input wdata,
                 output busy, output done, output err, output rdata,
                 output run, input rise, input fall);
    modport div (input run, output rise, output fall);
endinterface

/* design/seeac_clkdiv.sv */
`timescale 1ns/1ns
`include "seeac_params.svh"
module seeac_clkdiv (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Engine side
    seeac_ser_if.div ser,
    input wire logic [1:0] rate,
    // Serial clock pin
    output logic ee_sclk
);
    logic [8:0] cnt_q;
    logic [8:0] half;
    logic sclk_q;
    logic rise_q;
    logic fall_q;

    // Reserved rate codes fall back to the normal divider
    // R7 rate select
    assign half = (rate == `SEEAC_RATE_TEST) ? 9'(`SEEAC_DIV_TEST / 2 - 1)
                                              : 9'(`SEEAC_DIV_NORMAL / 2 - 1);

    // R8 core clock divider
    always_ff @(posedge clk) begin
        if (rst || !ser.run) begin
            cnt_q <= 9'h000;
            sclk_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else if (cnt_q >= half) begin
            cnt_q <= 9'h000;
            sclk_q <= ~sclk_q;
            rise_q <= ~sclk_q;
            fall_q <= sclk_q;
        end else begin
            cnt_q <= cnt_q + 9'h001;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
    end

    assign ee_sclk = sclk_q;
    assign ser.rise = rise_q;
    assign ser.fall = fall_q;
endmodule

/* design/seeac_serial.sv */
`timescale 1ns/1ns
`include "seeac_params.svh"
module seeac_serial (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    seeac_ser_if.eng ctl,
    // EEPROM pins
    output logic ee_cs,
    output logic ee_dout,
    input wire logic ee_din
);
    seeac_pkg::seeac_ser_state_t state_q;
    logic [25:0] tx_q;
    logic [26:0] rx_q;
    logic [4:0] bit_q;
    logic [4:0] total_q;
    logic wr_q;
    logic cs_q;
    logic [11:0] poll_q;
    logic done_q;
    logic err_q;
    logic [15:0] rdata_q;
    logic fin_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= seeac_pkg::SER_IDLE;
            tx_q <= 26'h0000000;
            rx_q <= 27'h0000000;
            bit_q <= 5'h00;
            total_q <= 5'h00;
            wr_q <= 1'b0;
            cs_q <= 1'b0;
            poll_q <= 12'h000;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 16'h0000;
            fin_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                seeac_pkg::SER_IDLE: if (ctl.req) begin
                    // R2 opcode from command
                    tx_q <= {1'b1, ctl.wr ? `SEEAC_OP_WRITE : `SEEAC_OP_READ,
                             ctl.addr, ctl.wr ? ctl.wdata : 16'h0000};
                    total_q <= ctl.wr ? `SEEAC_WR_BITS : `SEEAC_RD_BITS;
                    wr_q <= ctl.wr;
                    bit_q <= 5'h00;
                    cs_q <= 1'b1;
                    state_q <= seeac_pkg::SER_SHIFT;
                end
                seeac_pkg::SER_SHIFT: begin
                    if (ctl.rise) begin
                        rx_q <= {rx_q[25:0], ee_din};
                        bit_q <= bit_q + 5'h01;
                    end
                    if (ctl.fall && bit_q == total_q) begin
                        cs_q <= 1'b0;
                        if (wr_q) begin
                            state_q <= seeac_pkg::SER_GAP;
                        end else begin
                            // R3 dummy zero is the acknowledge
                            err_q <= rx_q[`SEEAC_DUMMY_POS];
                            rdata_q <= rx_q[15:0];
                            done_q <= 1'b1;
                            state_q <= seeac_pkg::SER_IDLE;
                        end
                    end else if (ctl.fall) begin
                        tx_q <= {tx_q[24:0], 1'b0};
                    end
                end
                seeac_pkg::SER_GAP: if (ctl.fall) begin
                    cs_q <= 1'b1;
                    poll_q <= 12'h000;
                    state_q <= seeac_pkg::SER_POLL;
                end
                seeac_pkg::SER_POLL: begin
                    // R3 ready never seen
                    if (ctl.rise && !fin_q) begin
                        if (ee_din || poll_q == `SEEAC_POLL_LIMIT) begin
                            err_q <= ~ee_din;
                            fin_q <= 1'b1;
                        end else begin
                            poll_q <= poll_q + 12'h001;
                        end
                    end
                    // Close on a fall so select drops with the clock low
                    if (ctl.fall && fin_q) begin
                        fin_q <= 1'b0;
                        cs_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= seeac_pkg::SER_IDLE;
                    end
                end
            endcase
        end
    end

    assign ee_cs = cs_q;
    assign ee_dout = tx_q[25];
    assign ctl.busy = (state_q != seeac_pkg::SER_IDLE);
    assign ctl.run = (state_q != seeac_pkg::SER_IDLE);
    assign ctl.done = done_q;
    assign ctl.err = err_q;
    assign ctl.rdata = rdata_q;
endmodule

/* design/seeac_top.sv */
`timescale 1ns/1ns
`include "seeac_params.svh"
module seeac_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq,
    // EEPROM pins
    output logic ee_sclk,
    output logic ee_cs,
    output logic ee_dout,
    input wire logic ee_din,
    // Configuration load port
    output logic cfg_load_valid,
    output logic [6:0] cfg_load_index,
    output logic [15:0] cfg_load_data
);
    // Control register state
    logic start_q;
    logic cmd_q;
    logic err_q;
    logic alok_q;
    logic alst_q;
    logic aldis_q;
    logic [1:0] rate_q;
    logic [6:0] addr_q;
    logic [15:0] data_q;

    // Interrupt state
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic irq_q;

    // Bus answer
    logic [31:0] rdata_q;

    // Engine arbitration
    logic req_q;
    logic req_wr_q;
    logic [6:0] req_addr_q;
    logic [15:0] req_data_q;
    logic inflight_q;
    logic owner_sw_q;

    // Autoload sequencer
    seeac_pkg::seeac_al_state_t al_state_q;
    logic [6:0] al_idx_q;
    logic al_bad_q;

    // Configuration load outputs
    logic cfg_valid_q;
    logic [6:0] cfg_index_q;
    logic [15:0] cfg_data_q;

    // Decodes
    logic ctrl_wr;
    logic ctrl_rd;
    logic stat_rd;
    logic mask_wr;
    logic idle;
    logic sw_done;
    logic al_done;
    logic al_success;
    logic al_fail;
    logic [2:0] events;

    seeac_ser_if ser ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // R11 single shared register
    assign ctrl_wr = reg_wr && hit(reg_addr, `SEEAC_CTRL_OFS);
    assign ctrl_rd = reg_rd && hit(reg_addr, `SEEAC_CTRL_OFS);
    assign stat_rd = reg_rd && hit(reg_addr, `SEEAC_STAT_OFS);
    assign mask_wr = reg_wr && hit(reg_addr, `SEEAC_MASK_OFS);

    assign idle = !req_q && !inflight_q && !ser.busy;
    assign sw_done = ser.done && owner_sw_q;
    assign al_done = ser.done && !owner_sw_q;

    // Autoload ends on last word, on a bad signature or on any error
    assign al_fail = al_done && (ser.err ||
                     (al_idx_q == 7'h00 && ser.rdata != `SEEAC_AL_SIG));
    assign al_success = al_done && !al_fail && al_idx_q == `SEEAC_AL_WORDS;

    // R1 launch arbitration
    always_ff @(posedge clk) begin
        if (rst) begin
            req_q <= 1'b0;
            req_wr_q <= 1'b0;
            req_addr_q <= 7'h00;
            req_data_q <= 16'h0000;
            inflight_q <= 1'b0;
            owner_sw_q <= 1'b0;
        end else begin
            req_q <= 1'b0;
            if (ser.done) begin
                inflight_q <= 1'b0;
            end
            if (idle && al_state_q == seeac_pkg::AL_RUN) begin
                // Autoload owns the engine until it ends
                req_q <= 1'b1;
                req_wr_q <= 1'b0;
                req_addr_q <= al_idx_q;
                inflight_q <= 1'b1;
                owner_sw_q <= 1'b0;
            end else if (idle && start_q && al_state_q != seeac_pkg::AL_ARMED) begin
                // R2 direction from command
                req_q <= 1'b1;
                req_wr_q <= cmd_q;
                // R9 word address
                req_addr_q <= addr_q;
                // R10 write data source
                req_data_q <= data_q;
                inflight_q <= 1'b1;
                owner_sw_q <= 1'b1;
            end
        end
    end

    assign ser.req = req_q;
    assign ser.wr = req_wr_q;
    assign ser.addr = req_addr_q;
    assign ser.wdata = req_data_q;

    // Autoload decided once, first cycle after reset; disable resets to one, so it never runs
    always_ff @(posedge clk) begin
        if (rst) begin
            al_state_q <= seeac_pkg::AL_ARMED;
            al_idx_q <= 7'h00;
            al_bad_q <= 1'b0;
        end else begin
            unique case (al_state_q)
                seeac_pkg::AL_ARMED: begin
                    // R6 disable gates the load
                    if (!aldis_q && idle) begin
                        al_state_q <= seeac_pkg::AL_RUN;
                        al_idx_q <= 7'h00;
                    end else if (aldis_q) begin
                        al_state_q <= seeac_pkg::AL_OVER;
                    end
                end
                seeac_pkg::AL_RUN: if (al_done) begin
                    if (al_fail || al_success) begin
                        al_bad_q <= al_fail;
                        al_state_q <= seeac_pkg::AL_OVER;
                    end else begin
                        al_idx_q <= al_idx_q + 7'h01;
                    end
                end
                seeac_pkg::AL_OVER: al_state_q <= seeac_pkg::AL_OVER;
                default: al_state_q <= seeac_pkg::AL_OVER;
            endcase
        end
    end

    // Loaded words go out to the configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_valid_q <= 1'b0;
            cfg_index_q <= 7'h00;
            cfg_data_q <= 16'h0000;
        end else begin
            cfg_valid_q <= al_done && !al_fail && al_idx_q != 7'h00;
            if (al_done) begin
                cfg_index_q <= al_idx_q;
                cfg_data_q <= ser.rdata;
            end
        end
    end

    // Start bit, software set, hardware clear
    always_ff @(posedge clk) begin
        if (rst) begin
            start_q <= 1'b0;
        end else if (sw_done) begin
            // R13 completion clears start
            start_q <= 1'b0;
        end else if (ctrl_wr && reg_wdata[`SEEAC_START_BIT]) begin
            // R1 start request
            start_q <= 1'b1;
        end
    end

    // Writable control fields
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_q <= `SEEAC_CMD_RST;
            aldis_q <= `SEEAC_ALDIS_RST;
            rate_q <= `SEEAC_RATE_RST;
            addr_q <= `SEEAC_ADDR_RST;
        end else if (ctrl_wr) begin
            // R2 command field
            cmd_q <= reg_wdata[`SEEAC_CMD_BIT];
            // R6 disable field
            aldis_q <= reg_wdata[`SEEAC_ALDIS_BIT];
            // R7 rate field
            rate_q <= reg_wdata[`SEEAC_RATE_MSB:`SEEAC_RATE_LSB];
            // R9 address field
            addr_q <= reg_wdata[`SEEAC_ADDR_MSB:`SEEAC_ADDR_LSB];
        end
    end

    // Returned word wins over a write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            data_q <= `SEEAC_DATA_RST;
        end else if (sw_done && !req_wr_q) begin
            // R10 read result loaded
            data_q <= ser.rdata;
        end else if (ctrl_wr) begin
            data_q <= reg_wdata[`SEEAC_DATA_MSB:`SEEAC_DATA_LSB];
        end
    end

    // Error flag follows the last finished cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (ser.done) begin
            // R3 missing acknowledge
            err_q <= ser.err;
        end
    end

    // Autoload result flags
    always_ff @(posedge clk) begin
        if (rst) begin
            alok_q <= 1'b0;
            alst_q <= 1'b0;
        end else begin
            // R4 set wins over read clear
            if (al_success) begin
                alok_q <= 1'b1;
            end else if (ctrl_rd) begin
                alok_q <= 1'b0;
            end
            // R5 loaded status
            if (al_success) begin
                alst_q <= 1'b1;
            end
        end
    end

    assign events[`SEEAC_IRQ_DONE] = sw_done;
    assign events[`SEEAC_IRQ_ERR] = ser.done && ser.err;
    assign events[`SEEAC_IRQ_AUTO] = al_success || al_fail;

    // Sticky status, read clears, set wins
    generate
        for (genvar i = 0; i < 3; i++) begin : g_stat
            always_ff @(posedge clk) begin
                if (rst) begin
                    stat_q[i] <= 1'b0;
                end else if (events[i]) begin
                    stat_q[i] <= 1'b1;
                end else if (stat_rd) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= 3'h0;
        end else if (mask_wr) begin
            mask_q <= reg_wdata[2:0];
        end
    end

    // One cycle behind status, so the pin is a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (ctrl_rd) begin
            // R11 packed layout, reserved bit 8 zero
            rdata_q <= {data_q, addr_q, 1'b0, rate_q, aldis_q, alst_q,
                        alok_q, err_q, cmd_q, start_q};
        end else if (stat_rd) begin
            rdata_q <= {29'h00000000, stat_q};
        end else if (reg_rd && hit(reg_addr, `SEEAC_MASK_OFS)) begin
            rdata_q <= {29'h00000000, mask_q};
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign cfg_load_valid = cfg_valid_q;
    assign cfg_load_index = cfg_index_q;
    assign cfg_load_data = cfg_data_q;

    // R8 serial clock from core clock
    seeac_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .ser(ser.div),
        .rate(rate_q),
        .ee_sclk(ee_sclk)
    );

    seeac_serial u_ser (
        .clk(clk),
        .rst(rst),
        .ctl(ser.eng),
        .ee_cs(ee_cs),
        .ee_dout(ee_dout),
        .ee_din(ee_din)
    );
endmodule

/* tb/seeac_top_properties.sv */
`timescale 1ns/1ns
module seeac_top_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Interrupt
    input wire logic irq,
    // EEPROM pins
    input wire logic ee_sclk,
    input wire logic ee_cs,
    input wire logic ee_dout,
    input wire logic ee_din,
    // Configuration load port
    input wire logic cfg_load_valid,
    input wire logic [6:0] cfg_load_index,
    input wire logic [15:0] cfg_load_data
);
    logic [1:0] rate_q;
    logic [9:0] hi_q;
    logic [3:0] idle_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            rate_q <= 2'h1;
        end else if (reg_wr && reg_addr == 8'hBC) begin
            rate_q <= reg_wdata[7:6];
        end
    end
    // High time of the serial clock, read at its fall
    always_ff @(posedge clk) begin
        hi_q <= ee_sclk ? hi_q + 10'h001 : 10'h000;
    end
    // Start only judged after a long quiet spell, so a write gap at test rate never counts
    always_ff @(posedge clk) begin
        if (rst || ee_cs) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hF) begin
            idle_q <= idle_q + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    property p_unmapped;
        reg_rd && reg_addr != 8'hBC && reg_addr != 8'hF0 && reg_addr != 8'hF4
            |=> reg_rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rsvd_zero;
        reg_rd && reg_addr == 8'hBC |=> !reg_rdata[8];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved control bit set");
    property p_load_flags;
        reg_rd && reg_addr == 8'hBC |=> reg_rdata[4:3] == 2'h0;
    endproperty
    a_load_flags: assert property (p_load_flags)
        else $error("load flags set without load");
    property p_start_cs;
        reg_wr && reg_addr == 8'hBC && reg_wdata[0] && idle_q == 4'hF
            |-> ##1 !ee_cs ##1 !ee_cs ##1 ee_cs;
    endproperty
    a_start_cs: assert property (p_start_cs)
        else $error("start did not open a frame");
    property p_cs_sclk;
        $fell(ee_cs) |-> !ee_sclk;
    endproperty
    a_cs_sclk: assert property (p_cs_sclk)
        else $error("frame closed with clock high");
    property p_half_period;
        $fell(ee_sclk) |-> hi_q == ((rate_q == 2'h3) ? 10'h002 : 10'h200);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("serial clock high time wrong");
    property p_dout_fall;
        ee_cs && $past(ee_cs) && $changed(ee_dout) |-> !ee_sclk && $past(ee_sclk, 2);
    endproperty
    a_dout_fall: assert property (p_dout_fall)
        else $error("serial data moved off clock fall");
    property p_irq_clear;
        reg_rd && reg_addr == 8'hF0 && !ee_cs |-> ##2 !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt stayed after status read");
    property p_no_load;
        !cfg_load_valid && cfg_load_index == 7'h00 && cfg_load_data == 16'h0000;
    endproperty
    a_no_load: assert property (p_no_load)
        else $error("load output while disabled");
endmodule

bind seeac_top seeac_top_properties u_seeac_top_properties (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .ee_sclk(ee_sclk), .ee_cs(ee_cs), .ee_dout(ee_dout),
    .ee_din(ee_din), .cfg_load_valid(cfg_load_valid), .cfg_load_index(cfg_load_index),
    .cfg_load_data(cfg_load_data));

/* tb/seeac_eeprom_model.sv */
`timescale 1ns/1ns
module seeac_eeprom_model (
    // Serial pins
    input wire logic sclk,
    input wire logic cs,
    input wire logic din,
    output logic dout,
    // Fault control
    input wire logic nak
);
    logic [15:0] mem [0:127];
    logic [9:0] cmd;
    logic [15:0] wd;
    logic stat = 1'h0;
    int cnt = 0;
    int busy = 0;

    initial begin
        dout = 1'h0;
    end
    always @(posedge cs) begin
        cnt = 0;
        dout = stat ? 1'h0 : ~dout;
    end
    // Word committed only on a whole write frame
    always @(negedge cs) begin
        if (!stat && cnt == 26 && cmd[8:7] == 2'h1) begin
            mem[cmd[6:0]] = wd;
            stat = 1'h1;
            busy = 3;
        end else begin
            stat = 1'h0;
        end
        dout = ~dout;
    end
    always @(posedge sclk) begin
        if (cs) begin
            cnt = cnt + 1;
            if (cnt <= 10)
                cmd = {cmd[8:0], din};
            else
                wd = {wd[14:0], din};
            if (stat && busy > 0)
                busy = busy - 1;
        end
    end
    // ack as dummy bit or ready
    always @(negedge sclk) begin
        if (cs && stat)
            dout = !nak && busy == 0;
        else if (cs && cmd[8:7] == 2'h2 && cnt >= 10 && cnt <= 26)
            dout = (cnt == 10) ? nak : mem[cmd[6:0]][26 - cnt];
        else
            dout = ~dout;
    end
endmodule

/* tb/seeac_bench.sv */
`timescale 1ns/1ns
module seeac_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic nak = 1'h0;
    logic [31:0] reg_rdata;
    logic irq;
    logic ee_sclk;
    logic ee_cs;
    logic ee_dout;
    logic ee_din;
    logic [31:0] got;
    logic [6:0] ad_t [2] = '{7'h00, 7'h7F};
    logic [15:0] wd_t [2] = '{16'hC35A, 16'h81E7};
    int mismatches = 0;
    int samples_checked = 0;

    always #4 clk = ~clk;

    seeac_top u_seeac_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .ee_sclk(ee_sclk),
        .ee_cs(ee_cs), .ee_dout(ee_dout), .ee_din(ee_din), .cfg_load_valid(),
        .cfg_load_index(), .cfg_load_data());
    seeac_eeprom_model u_seeac_eeprom_model (.sclk(ee_sclk), .cs(ee_cs), .din(ee_dout),
        .dout(ee_din), .nak(nak));

    task automatic complete_run;
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check32(input logic [31:0] g, input logic [31:0] e, input string what);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, g, e);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
        @(posedge clk);
    endtask
    // Launch, then poll the start bit under a bound
    task automatic run_cycle(input logic [31:0] c, output logic [31:0] d);
        int n;
        n = 0;
        d = c;
        reg_write(8'hBC, c);
        while (d[0] !== 1'h0 && n < 20000) begin
            reg_read(8'hBC, d);
            n++;
        end
        check32({31'h0, d[0]}, 32'h00000000, "start");
    endtask
    task automatic check_status(input logic [31:0] e, input logic ie);
        logic [31:0] s;
        check32({31'h0, irq}, {31'h0, ie}, "irq level");
        reg_read(8'hF0, s);
        check32(s, e, "status");
        #1;
        check32({31'h0, irq}, 32'h00000000, "irq clear");
    endtask
    function automatic logic [31:0] ctl(input logic [15:0] d, input logic [6:0] a,
        input logic [1:0] r, input logic e, input logic c, input logic s);
        return {d, a, 1'h0, r, 1'h1, 2'h0, e, c, s};
    endfunction

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        reg_read(8'hBC, got);
        check32(got, 32'h00000060, "control reset");
        reg_read(8'hF0, got);
        check32(got, 32'h00000000, "status reset");
        reg_write(8'hC0, 32'hFFFFFFFF);
        reg_read(8'hC0, got);
        check32(got, 32'h00000000, "unmapped");
        reg_read(8'hBC, got);
        check32(got, 32'h00000060, "control kept");
        reg_write(8'hF4, 32'h00000007);
        reg_read(8'hF4, got);
        check32(got, 32'h00000007, "mask");
        for (int i = 0; i < 2; i++) begin
            run_cycle(ctl(wd_t[i], ad_t[i], 2'h3, 1'h0, 1'h1, 1'h1), got);
            check32(got, ctl(wd_t[i], ad_t[i], 2'h3, 1'h0, 1'h1, 1'h0), "write");
            check_status(32'h00000001, 1'h1);
        end
        for (int i = 0; i < 2; i++) begin
            run_cycle(ctl(16'h0000, ad_t[i], 2'h3, 1'h0, 1'h0, 1'h1), got);
            check32(got, ctl(wd_t[i], ad_t[i], 2'h3, 1'h0, 1'h0, 1'h0), "read");
            check_status(32'h00000001, 1'h1);
        end
        nak <= 1'h1;
        run_cycle(ctl(16'h0000, ad_t[0], 2'h3, 1'h0, 1'h0, 1'h1), got);
        check32(got & 32'h0000FFFF, ctl(16'h0000, ad_t[0], 2'h3, 1'h1, 1'h0, 1'h0), "nak rd");
        check_status(32'h00000003, 1'h1);
        run_cycle(ctl(16'h1234, 7'h2A, 2'h3, 1'h0, 1'h1, 1'h1), got);
        check32(got, ctl(16'h1234, 7'h2A, 2'h3, 1'h1, 1'h1, 1'h0), "nak wr");
        check_status(32'h00000003, 1'h1);
        nak <= 1'h0;
        reg_write(8'hF4, 32'h00000000);
        @(posedge clk);
        run_cycle(ctl(16'h0000, ad_t[1], 2'h1, 1'h0, 1'h0, 1'h1), got);
        check32(got, ctl(wd_t[1], ad_t[1], 2'h1, 1'h0, 1'h0, 1'h0), "slow read");
        check_status(32'h00000001, 1'h0);
        complete_run();
    end

    // Whole run is near 45000 cycles
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule
